// >>> core/gpt_top.sv
// general purpose pins, fetch and master indications, and the pin connectivity tree test
// assumes: config writes come from the device's pci config logic; reads of the
// operating register are served by the device register file from level_reg_o
`timescale 1ns/1ns
module gpt_top #(
  parameter int unsigned EXTRA_PINS = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // pins from the board
  input  wire logic        tree_test_input_b_i,
  input  wire logic [4:0]  gpio_in_i,
  output logic      [4:0]  gpio_out_o,
  output logic      [4:0]  gpio_oe_o,
  output logic      [4:0]  gpio_pullup_o,
  // other non-scsi device pins joining the tree, their pull-ups and driver kill
  input  wire logic [EXTRA_PINS-1:0] extra_in_i,
  output logic             extra_pullup_o,
  output logic             driver_kill_o,
  output logic             tree_test_output_o,
  output logic             tree_test_output_oe_o,
  // internal status
  input  wire logic        fetch_next_i,
  input  wire logic        bus_master_i,
  // config space write port
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [17:0] cfg_wdata_i,
  output logic      [17:0] cfg_rdata_o,
  // operating register value
  output logic      [7:0]  level_reg_o
);
  initial begin
    if (EXTRA_PINS < 1) $error("need at least one extra tree pin");
  end

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers for pin inputs
  logic [4:0]            gp_s1, gp_s2;
  logic [EXTRA_PINS-1:0] ex_s1, ex_s2;
  logic                  tt_s1, tt_s2;
  always_ff @(posedge clk_i) begin
    gp_s1 <= gpio_in_i;
    gp_s2 <= gp_s1;
    ex_s1 <= extra_in_i;
    ex_s2 <= ex_s1;
    tt_s1 <= tree_test_input_b_i;
    tt_s2 <= tt_s1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode
  gpt_pkg::gpt_mode_type mode;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) mode <= gpt_pkg::MODE_NORMAL;
    else mode <= tt_s2 ? gpt_pkg::MODE_NORMAL : gpt_pkg::MODE_TREE;
  end
  wire logic tree_mode = (mode == gpt_pkg::MODE_TREE);

  //////////////////////////////////////////////////////////////////////////////
  // control register at the config location
  logic [4:0] dir;
  logic [4:0] out_val;
  logic       fetch_en;
  logic       master_en;
  wire logic  ctrl_hit = cfg_wr_i && (cfg_addr_i == gpt_pkg::CFG_PIN_CTRL);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dir       <= gpt_pkg::DIR_RESET;
      out_val   <= gpt_pkg::OUT_RESET;
      fetch_en  <= 1'b0;
      master_en <= 1'b0;
    end else if (ctrl_hit) begin
      dir       <= cfg_wdata_i[gpt_pkg::FLD_DIR_LSB +: 5];
      out_val   <= cfg_wdata_i[gpt_pkg::FLD_OUT_LSB +: 5];
      fetch_en  <= cfg_wdata_i[gpt_pkg::FLD_FETCH_EN];
      master_en <= cfg_wdata_i[gpt_pkg::FLD_MASTER_EN];
    end
  end
  assign cfg_rdata_o = (cfg_addr_i == gpt_pkg::CFG_PIN_CTRL) ?
                       {master_en, fetch_en, 3'h0, out_val, 3'h0, dir} : 18'h00000;

  //////////////////////////////////////////////////////////////////////////////
  // pin drive
  wire logic [4:0] func_val;
  wire logic [4:0] func_oe;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      if (gi == gpt_pkg::PIN_FETCH) begin : g_fetch
        assign func_val[gi] = fetch_en ? ~fetch_next_i : out_val[gi];
        assign func_oe[gi]  = fetch_en | dir[gi];
      end else if (gi == gpt_pkg::PIN_MASTER) begin : g_master
        assign func_val[gi] = master_en ? ~bus_master_i : out_val[gi];
        assign func_oe[gi]  = master_en | dir[gi];
      end else begin : g_plain
        assign func_val[gi] = out_val[gi];
        assign func_oe[gi]  = dir[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      gpio_out_o <= gpt_pkg::OUT_RESET;
      gpio_oe_o  <= gpt_pkg::DIR_RESET;
    end else begin
      gpio_out_o <= func_val;
      gpio_oe_o  <= tree_mode ? 5'h00 : func_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tree test; scsi lines are not ports of this block so cannot enter it
  wire logic tree_result;
  gpt_and_tree #(
    .WIDTH (EXTRA_PINS + 5)
  ) u_tree (
    .level_i  ({ex_s2, gp_s2}),
    .result_o (tree_result)
  );
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) tree_test_output_o <= 1'b1;
    else tree_test_output_o <= tree_result;
  end
  assign tree_test_output_oe_o = tree_mode;
  assign gpio_pullup_o  = {5{tree_mode}};
  assign extra_pullup_o = tree_mode;
  assign driver_kill_o  = tree_mode;

  //////////////////////////////////////////////////////////////////////////////
  // operating register shows pin levels
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) level_reg_o <= 8'h00;
    else level_reg_o <= {3'h0, gp_s2};
  end
endmodule // gpt_top

// >>> core/gpt_pkg.sv
// package: constants for the general pin and tree test block
// assumes: used by gpt_top, referenced as gpt_pkg::name
package gpt_pkg;
  localparam int unsigned PIN_COUNT       = 5;
  // configuration space location holding general pin control
  localparam logic [7:0]  CFG_PIN_CTRL    = 8'h35;
  // operating register reflecting pin levels
  localparam logic [7:0]  LEVEL_REG_ADDR  = 8'h07;
  // control word layout at the configuration location
  localparam int unsigned FLD_DIR_LSB     = 0;
  localparam int unsigned FLD_OUT_LSB     = 8;
  localparam int unsigned FLD_FETCH_EN    = 16;
  localparam int unsigned FLD_MASTER_EN   = 17;
  // pin indices
  localparam int unsigned PIN_FETCH       = 0;
  localparam int unsigned PIN_MASTER      = 1;
  localparam int unsigned PIN_THREE       = 3;
  localparam int unsigned PIN_FOUR        = 4;
  // power-up direction: 1 = output; only general pin four drives
  localparam logic [4:0]  DIR_RESET       = 5'h10;
  localparam logic [4:0]  OUT_RESET       = 5'h00;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h1,
    MODE_TREE   = 2'h2
  } gpt_mode_type;
endpackage

// >>> core/gpt_and_tree.sv
// and tree combining the tree pin levels into one result
// assumes: inputs are already synchronised pin levels
`timescale 1ns/1ns
module gpt_and_tree #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] level_i,
  output wire logic             result_o
);
  initial begin
    if (WIDTH < 1) $error("width must be at least one");
  end
  wire logic [WIDTH-1:0] chain;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_stage
      if (gi == 0) begin : g_first
        assign chain[gi] = level_i[gi];
      end else begin : g_next
        assign chain[gi] = chain[gi-1] & level_i[gi];
      end
    end
  endgenerate
  assign result_o = chain[WIDTH-1];
endmodule // gpt_and_tree

// >>> tb/gpt_props.sv
// checker on gpt_top ports
// assumes: bound into gpt_top
`timescale 1ns/1ns
module gpt_props #(parameter int unsigned EXTRA_PINS = 4) (
  input wire logic clk_i, rst_b_i, tree_test_input_b_i, cfg_wr_i, fetch_next_i, bus_master_i,
  input wire logic driver_kill_o, tree_test_output_o, tree_test_output_oe_o,
  input wire logic [4:0] gpio_in_i, gpio_out_o, gpio_oe_o, gpio_pullup_o,
  input wire logic [EXTRA_PINS-1:0] extra_in_i,
  input wire logic [7:0] cfg_addr_i, level_reg_o,
  input wire logic [17:0] cfg_wdata_i, cfg_rdata_o
);
  logic [17:0] ctl;
  always_ff @(posedge clk_i)
    if (!rst_b_i) ctl <= 18'h10;
    else if (cfg_wr_i && cfg_addr_i == 8'h35) ctl <= cfg_wdata_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_calm; (!cfg_wr_i && tree_test_input_b_i)[*6]; endsequence
  chk_reset_dirs: assert property (!$past(rst_b_i) |-> gpio_oe_o == 5'h10)
    else $error("dirs");
  chk_tree_mode: assert property ((!tree_test_input_b_i)[*7] |->
    tree_test_output_oe_o && driver_kill_o && gpio_pullup_o == 5'h1f && gpio_oe_o == 5'h0)
    else $error("tree");
  chk_tree_result: assert property ($stable({gpio_in_i, extra_in_i})[*5] |->
    tree_test_output_o == &{gpio_in_i, extra_in_i}) else $error("and");
  chk_level_view: assert property ($stable(gpio_in_i)[*5] |->
    level_reg_o == {3'h0, gpio_in_i}) else $error("level");
  chk_pin_ctl: assert property (s_calm |->
    gpio_oe_o == (ctl[4:0] | {3'h0, ctl[17:16]})) else $error("ctl");
  chk_fetch_low: assert property (s_calm ##0 ctl[16] |->
    gpio_out_o[0] == !$past(fetch_next_i)) else $error("fetch");
  chk_master_low: assert property (s_calm ##0 ctl[17] |->
    gpio_out_o[1] == !$past(bus_master_i)) else $error("master");
  chk_ctl_readback: assert property (
    cfg_rdata_o == (cfg_addr_i == 8'h35 ? (ctl & 18'h31f1f) : 18'h0)) else $error("read");
endmodule // gpt_props

// >>> tb/gpt_board.sv
// board model: pins with tester drive and pull-ups
// assumes: tester masks come from the bench
`timescale 1ns/1ns
module gpt_board (
  input  wire logic       clk_i,
  input  wire logic [4:0] gpio_out_o, gpio_oe_o, gpio_pullup_o, ext, ext_en,
  output logic      [4:0] gpio_in_i
);
  logic [4:0] flt = 5'h0;
  always @(posedge clk_i) flt <= ~flt;
  // an undriven pin without pull-up floats, so it shows a changing value
  assign gpio_in_i = gpio_oe_o & gpio_out_o | ~gpio_oe_o & (ext_en & ext
    | ~ext_en & (gpio_pullup_o | flt));
endmodule // gpt_board

// >>> tb/general_pins_and_tree_test_bench.sv
// bench: random pin traffic and tree sweep
// assumes: gpt_board and gpt_props
`timescale 1ns/1ns
module general_pins_and_tree_test_bench;
  logic clk_i = 0, rst_b_i = 0, cfg_wr_i = 0, fetch_next_i = 0, bus_master_i = 0;
  logic tree_test_input_b_i = 1, extra_pullup_o, driver_kill_o, tree_test_output_o;
  logic tree_test_output_oe_o;
  logic [4:0] ext = 0, ext_en = 5'h1f, gpio_in_i, gpio_out_o, gpio_oe_o, gpio_pullup_o;
  logic [3:0] extra_in_i = 4'hf;
  logic [7:0] cfg_addr_i = 8'h35, level_reg_o;
  logic [17:0] cfg_wdata_i = 0, cfg_rdata_o, c = 18'h10;
  logic [31:0] w;
  int errors = 0, checked = 0;
  gpt_top dut (.*);
  gpt_board board (.*);
  task automatic check(input logic [17:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [17:0] dirs(input logic [17:0] v);
    return {13'h0, v[4:0] | {3'h0, v[17:16]}};
  endfunction
  // pin levels seen on the board: driven pins show the drive, others the tester
  function automatic logic [17:0] pins(input logic [17:0] v, input logic f, m,
                                       input logic [4:0] e);
    logic [4:0] d;
    logic [4:0] o;
    d = v[4:0] | {3'h0, v[17:16]};
    o = v[12:8];
    if (v[16]) o[0] = !f;
    if (v[17]) o[1] = !m;
    return {13'h0, d & o | ~d & e};
  endfunction
  initial forever #2 clk_i = !clk_i;
  initial begin
    #20000 errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(91));
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1;
    for (int k = 0; k < 60; k++) begin
      w = $urandom;
      @(posedge clk_i);
      cfg_addr_i <= k % 4 == 3 ? 8'h47 : 8'h35;
      {cfg_wr_i, cfg_wdata_i, fetch_next_i, bus_master_i, ext, extra_in_i} <= {1'b1, w[28:0]};
      if (k % 4 != 3) c = w[28:11];
      @(posedge clk_i);
      {cfg_wr_i, cfg_addr_i} <= {1'b0, 8'h35};
      repeat (5) @(posedge clk_i);
      #1 check(18'(gpio_oe_o), dirs(c));
      check(cfg_rdata_o, c & 18'h31f1f);
      check(18'(level_reg_o), pins(c, fetch_next_i, bus_master_i, ext));
      check(18'(gpio_out_o & gpio_oe_o), pins(c, fetch_next_i, bus_master_i, ext) & dirs(c));
    end
    @(posedge clk_i);
    {ext, ext_en, tree_test_input_b_i, extra_in_i} <= 15'h000f;
    repeat (8) @(posedge clk_i);
    #1 check({tree_test_output_oe_o, driver_kill_o, extra_pullup_o, gpio_pullup_o, gpio_oe_o},
             18'h1fe0);
    check(18'(tree_test_output_o), 18'h1);
    for (int p = 0; p < 9; p++) begin
      @(posedge clk_i);
      {extra_in_i, ext_en} <= 9'h1e0 ^ (9'h1 << p);
      repeat (5) @(posedge clk_i);
      #1 check(18'(tree_test_output_o), 18'h0);
    end
    tally_and_finish();
  end
endmodule // general_pins_and_tree_test_bench
bind gpt_top gpt_props #(.EXTRA_PINS(EXTRA_PINS)) chk (.*);
